/* verilog/ebc_defines.vh */
// constants for the external bus block control
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH
// register byte offsets
`define EBC_OFF_TYPE 8'h00
`define EBC_OFF_WIDTH 8'h04
`define EBC_OFF_WAIT 8'h08
`define EBC_OFF_DRAM 8'h0c
`define EBC_OFF_PINS 8'h10
`define EBC_OFF_STAT 8'h14
// reset values
`define EBC_RST_TYPE 16'h0000
`define EBC_RST_WIDTH_M0 16'h5555
`define EBC_RST_WIDTH_M1 16'h0000
`define EBC_RST_WAIT 24'hffffff
`define EBC_RST_DRAM 16'h0000
`define EBC_RST_PINS 32'hffffffff
// pin function bits inside the pin register
`define EBC_PIN_BUS 0
`define EBC_PIN_CS0 8
`define EBC_PIN_STROBE 16
`define EBC_PIN_WAIT 30
`define EBC_PIN_CLK 31
// device type and width codes
`define EBC_T_SRAM 2'h0
`define EBC_T_PROM 2'h1
`define EBC_T_DRAM 2'h2
`define EBC_W_16 2'h1
// access sizes
`define EBC_SZ_BYTE 2'h0
`define EBC_SZ_HALF 2'h1
`define EBC_SZ_WORD 2'h2
// clocks per access before waits
`define EBC_CLK_SRAM 4'h2
`define EBC_CLK_DRAM 4'h3
`define EBC_CLK_DRAM_BURST 4'h1
`define EBC_CLK_FLY_RD 4'h2
`define EBC_CLK_FLY_WR 4'h3
`define EBC_CLK_RAM 4'h1
`define EBC_CLK_RAM_FETCH 4'h2
`define EBC_CLK_PERI 3'h3
// peripheral register classes
`define EBC_PC_OTHER 2'h0
`define EBC_PC_CAPTURE 2'h1
`define EBC_PC_COMPARE 2'h2
`define EBC_PC_COUNT4 2'h3
`endif

/* verilog/ebc_top.v */
// external bus block control with axi4-lite register slave
`timescale 1ns/1ps
`include "ebc_defines.vh"
// Behaviour
// RULE1: 64 MB split into 2/4/8 MB blocks
// RULE2: two-bit device type per block
// RULE3: software keeps block 0 off dram
// RULE4: software sets device type once
// RULE5: selects for blocks 0,3-5, row strobes
// RULE6: unselected blocks still use their settings
// RULE7: internal ram one or two clocks
// RULE8: sram, rom, io two plus waits
// RULE9: dram three, burst one, flyby variants
// RULE10: each wait adds one clock
// RULE11: peripheral access off bus, parallel
// RULE12: peripheral three clocks, timer exceptions
// RULE13: two-bit width code, 8 or 16
// RULE14: width reset follows boot mode
// RULE15: software sets width once
// RULE16: 8-bit blocks use low strobe only
// RULE17: multi-cycle accesses lowest part first
// RULE18: halfword one or two cycles
// RULE19: word two halfwords or four bytes
// RULE20: pins in bus function after reset
// RULE21: pin function registers switch pins
// RULE22: dram kind chosen per block
// RULE23: wait count 0-7, reset 7
// RULE24: waits are max of programmed, external
// RULE25: byte lane by address on 16-bit
module ebc_top (
	input wire core_clk, // system clock
	input wire sys_rst, // async reset, high
	input wire clk_en, // freezes all state when low
	input wire boot_romless1, // boot mode strap, high for mode 1
	input wire [7:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // byte strobes
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [7:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire mem_req, // memory request pulse
	input wire mem_write, // write when high
	input wire mem_fetch, // instruction fetch
	input wire mem_burst, // burst continuation
	input wire mem_flyby, // dma flyby cycle
	input wire mem_internal, // internal ram target
	input wire [1:0] mem_size, // 0 byte, 1 half, 2 word
	input wire [25:0] mem_addr, // byte address
	input wire [31:0] mem_wdata, // write data
	output reg mem_ack, // done pulse
	output reg [31:0] mem_rdata, // read data
	output reg mem_busy, // request not accepted
	input wire per_req, // peripheral request pulse
	input wire per_write, // peripheral write
	input wire [1:0] per_class, // register class
	input wire per_extra_wait, // peripheral asks one wait
	output reg per_ack, // peripheral done pulse
	output reg per_busy, // peripheral access running
	output reg [25:0] ext_addr, // address bus
	output reg ext_addr_oe_n, // address drive, low drives
	output reg [15:0] ext_data_out, // data bus out
	input wire [15:0] ext_data_in, // data bus in
	output reg ext_data_lo_oe_n, // low lane drive, low drives
	output reg ext_data_hi_oe_n, // high lane drive, low drives
	output reg block0_select_n, // block 0 select
	output reg block3_select_n, // block 3 select or row strobe
	output reg block4_select_n, // block 4 select or row strobe
	output reg block5_select_n, // block 5 select or row strobe
	output reg low_byte_write_n, // low byte write strobe
	output reg high_byte_write_n, // high byte write strobe
	output reg io_read_n, // read strobe
	output reg low_col_strobe_n, // dram low column strobe
	output reg high_col_strobe_n, // dram high column strobe
	output reg cycle_begin_n, // bus cycle start
	input wire ext_wait_n, // external wait, low waits
	output reg sys_clock_out, // clock out, half rate
	output reg [1:0] dram_access_kind // dram kind of current block
);
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_CAP = 2'h2;

	reg [15:0] device_type;
	reg [15:0] bus_width;
	reg [23:0] wait_count;
	reg [15:0] dram_kind_select;
	reg [31:0] pin_func;
	reg strapped;
	reg boot_mode1;
	reg [7:0] aw_q;
	reg aw_hold;
	reg [31:0] w_q;
	reg [3:0] ws_q;
	reg w_hold;

	reg [1:0] state;
	reg [25:0] a_addr;
	reg [1:0] a_size;
	reg a_write;
	reg [31:0] a_wdata;
	reg a_int;
	reg a_fetch2;
	reg a_flyby;
	reg a_burst;
	reg [2:0] a_blk;
	reg [1:0] a_type;
	reg a_w16;
	reg [1:0] beat;
	reg [1:0] nbeats_m1;
	reg [3:0] cnt;
	reg [31:0] rbuf;
	reg [1:0] c_pos;
	reg c_hi;
	reg c_wide;
	reg [2:0] per_cnt;
	reg [2:0] per_tot_m1;

	wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
	wire do_wr = aw_hold & w_hold & ~s_axi_bvalid;
	wire [2:0] hb = mem_addr[25:23];
	wire wait_on = pin_func[`EBC_PIN_WAIT];
	wire strobe_on = pin_func[`EBC_PIN_STROBE];
	wire bus_on = pin_func[`EBC_PIN_BUS];
	wire run_ext = (state == ST_RUN) & ~a_int;
	wire is_dram = (a_type == `EBC_T_DRAM);
	wire wide_beat = a_w16 & (a_size != `EBC_SZ_BYTE);
	reg [2:0] next_blk;
	reg [1:0] next_nb_m1;
	reg [3:0] base;
	reg [3:0] total_m1;
	reg [1:0] pos;
	reg use_lo;
	reg use_hi;
	reg [31:0] wsh;
	reg [2:0] per_extra;
	wire [3:0] sel_vec;

	// RULE1: block decode
	always @* begin
		if (hb == 3'h0)
			next_blk = mem_addr[22] ? 3'h2 : (mem_addr[21] ? 3'h1 : 3'h0);
		else if (hb <= 3'h5)
			next_blk = hb + 3'h2;
		else
			next_blk = 3'h7;
	end

	// RULE18: beats per access
	always @* begin
		case (mem_size)
		`EBC_SZ_HALF: next_nb_m1 = (bus_width[{next_blk, 1'b0} +: 2] == `EBC_W_16) ? 2'h0 : 2'h1;
		// RULE19: word beat count
		`EBC_SZ_WORD: next_nb_m1 = (bus_width[{next_blk, 1'b0} +: 2] == `EBC_W_16) ? 2'h1 : 2'h3;
		default: next_nb_m1 = 2'h0;
		endcase
	end

	// beat length and lane choice
	always @* begin
		if (a_int) begin
			// RULE7: internal ram clocks
			base = a_fetch2 ? `EBC_CLK_RAM_FETCH : `EBC_CLK_RAM;
		end else if (is_dram) begin
			// RULE9: dram clock counts
			if (a_flyby)
				base = a_write ? `EBC_CLK_FLY_WR : ((a_burst | beat != 2'h0) ? `EBC_CLK_FLY_RD : `EBC_CLK_DRAM);
			else
				base = (a_burst | beat != 2'h0) ? `EBC_CLK_DRAM_BURST : `EBC_CLK_DRAM;
		end else begin
			// RULE8: sram, rom, page rom
			base = `EBC_CLK_SRAM;
		end
		// RULE10: one clock per wait
		// RULE23: programmed wait count
		total_m1 = a_int ? base - 4'h1 : base + {1'b0, wait_count[a_blk * 3 +: 3]} - 4'h1;
		// RULE17: lowest part first
		if (a_size == `EBC_SZ_BYTE)
			pos = 2'h0;
		else
			pos = a_w16 ? {beat[0], 1'b0} : beat;
		wsh = a_wdata >> {pos, 3'h0};
		// RULE25: byte lane by address
		use_lo = ~a_w16 | wide_beat | ~a_addr[0];
		use_hi = a_w16 & (wide_beat | a_addr[0]);
	end

	// RULE24: external wait extends beat
	wire beat_done = (cnt >= total_m1) & (a_int | ~wait_on | ext_wait_n);

	// RULE12: peripheral extra clocks
	always @* begin
		case (per_class)
		`EBC_PC_CAPTURE: per_extra = per_write ? {2'h0, per_extra_wait} : 3'h1;
		`EBC_PC_COMPARE: per_extra = per_write ? {2'h0, per_extra_wait} : 3'h0;
		`EBC_PC_COUNT4: per_extra = per_write ? 3'h0 : {2'h0, per_extra_wait};
		default: per_extra = 3'h0;
		endcase
	end

	// RULE5: select pins per block
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sel
			localparam [2:0] BLK = (gi == 0) ? 3'h0 : gi + 2;
			// RULE5: block 0 has no row strobe
			assign sel_vec[gi] = run_ext & (a_blk == BLK) & pin_func[`EBC_PIN_CS0 + BLK] & ((gi != 0) | ~is_dram);
		end
	endgenerate

	// register slave and configuration
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0;
			aw_q <= 8'h0;
			aw_hold <= 1'b0;
			w_q <= 32'h0;
			ws_q <= 4'h0;
			w_hold <= 1'b0;
			device_type <= `EBC_RST_TYPE;
			bus_width <= `EBC_RST_WIDTH_M0;
			wait_count <= `EBC_RST_WAIT;
			dram_kind_select <= `EBC_RST_DRAM;
			// RULE20: bus function after reset
			pin_func <= `EBC_RST_PINS;
			strapped <= 1'b0;
			boot_mode1 <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_q <= s_axi_awaddr;
				aw_hold <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
				w_hold <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (aw_q)
				// RULE2: device type field
				`EBC_OFF_TYPE: device_type <= (device_type & ~wmask[15:0]) | (w_q[15:0] & wmask[15:0]);
				// RULE13: width field
				`EBC_OFF_WIDTH: bus_width <= (bus_width & ~wmask[15:0]) | (w_q[15:0] & wmask[15:0]);
				`EBC_OFF_WAIT: wait_count <= (wait_count & ~wmask[23:0]) | (w_q[23:0] & wmask[23:0]);
				// RULE22: dram kind per block
				`EBC_OFF_DRAM: dram_kind_select <= (dram_kind_select & ~wmask[15:0]) | (w_q[15:0] & wmask[15:0]);
				// RULE21: pin function switching
				`EBC_OFF_PINS: pin_func <= (pin_func & ~wmask) | (w_q & wmask);
				`EBC_OFF_STAT: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
				`EBC_OFF_TYPE: s_axi_rdata <= {16'h0, device_type};
				`EBC_OFF_WIDTH: s_axi_rdata <= {16'h0, bus_width};
				`EBC_OFF_WAIT: s_axi_rdata <= {8'h0, wait_count};
				`EBC_OFF_DRAM: s_axi_rdata <= {16'h0, dram_kind_select};
				`EBC_OFF_PINS: s_axi_rdata <= pin_func;
				`EBC_OFF_STAT: s_axi_rdata <= {24'h0, a_blk, boot_mode1, strapped, per_busy, 1'b0, mem_busy};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end
			if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			// RULE14: width reset by boot mode
			if (~strapped) begin
				strapped <= 1'b1;
				boot_mode1 <= boot_romless1;
				bus_width <= boot_romless1 ? `EBC_RST_WIDTH_M1 : `EBC_RST_WIDTH_M0;
			end
		end
	end

	// memory access engine
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			mem_busy <= 1'b1;
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			a_addr <= 26'h0;
			a_size <= 2'h0;
			a_write <= 1'b0;
			a_wdata <= 32'h0;
			a_int <= 1'b0;
			a_fetch2 <= 1'b0;
			a_flyby <= 1'b0;
			a_burst <= 1'b0;
			a_blk <= 3'h0;
			a_type <= 2'h0;
			a_w16 <= 1'b0;
			beat <= 2'h0;
			nbeats_m1 <= 2'h0;
			cnt <= 4'h0;
			rbuf <= 32'h0;
			c_pos <= 2'h0;
			c_hi <= 1'b0;
			c_wide <= 1'b0;
		end else if (clk_en) begin
			mem_ack <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (~strapped) begin
					mem_busy <= 1'b1;
				end else if (mem_req) begin
					state <= ST_RUN;
					mem_busy <= 1'b1;
					a_addr <= mem_addr;
					a_size <= mem_size;
					a_write <= mem_write;
					a_wdata <= mem_wdata;
					a_int <= mem_internal;
					a_fetch2 <= mem_fetch & mem_addr[1];
					a_flyby <= mem_flyby;
					a_burst <= mem_burst;
					// RULE6: settings apply to every block
					a_blk <= next_blk;
					a_type <= (device_type[{next_blk, 1'b0} +: 2] == `EBC_T_DRAM) ? `EBC_T_DRAM : `EBC_T_SRAM;
					a_w16 <= bus_width[{next_blk, 1'b0} +: 2] == `EBC_W_16;
					nbeats_m1 <= mem_internal ? 2'h0 : next_nb_m1;
					beat <= 2'h0;
					cnt <= 4'h0;
					rbuf <= 32'h0;
				end else begin
					mem_busy <= 1'b0;
				end
			end
			ST_RUN: begin
				if (~beat_done) begin
					if (cnt != 4'hf)
						cnt <= cnt + 4'h1;
				end else begin
					cnt <= 4'h0;
					c_pos <= pos;
					c_hi <= ~wide_beat & use_hi;
					c_wide <= wide_beat;
					if (~a_int & ~a_write) begin
						state <= ST_CAP;
					end else if (beat == nbeats_m1) begin
						state <= ST_IDLE;
						mem_busy <= 1'b0;
						mem_ack <= 1'b1;
					end else begin
						beat <= beat + 2'h1;
					end
				end
			end
			ST_CAP: begin
				// pins lag one clock, so the data is taken here
				if (c_wide)
					rbuf[{c_pos, 3'h0} +: 16] <= ext_data_in;
				else
					rbuf[{c_pos, 3'h0} +: 8] <= c_hi ? ext_data_in[15:8] : ext_data_in[7:0];
				if (beat == nbeats_m1) begin
					state <= ST_IDLE;
					mem_busy <= 1'b0;
					mem_ack <= 1'b1;
					if (c_wide)
						mem_rdata <= c_pos[1] ? {ext_data_in, rbuf[15:0]} : {rbuf[31:16], ext_data_in};
					else
						mem_rdata <= rbuf | ({24'h0, c_hi ? ext_data_in[15:8] : ext_data_in[7:0]} << {c_pos, 3'h0});
				end else begin
					beat <= beat + 2'h1;
					state <= ST_RUN;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// RULE11: peripheral path runs on its own
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			per_busy <= 1'b0;
			per_ack <= 1'b0;
			per_cnt <= 3'h0;
			per_tot_m1 <= 3'h0;
		end else if (clk_en) begin
			per_ack <= 1'b0;
			if (~per_busy) begin
				if (per_req) begin
					per_busy <= 1'b1;
					per_cnt <= 3'h0;
					// RULE12: three clocks plus extra
					per_tot_m1 <= `EBC_CLK_PERI + per_extra - 3'h1;
				end
			end else if (per_cnt == per_tot_m1) begin
				per_busy <= 1'b0;
				per_ack <= 1'b1;
			end else begin
				per_cnt <= per_cnt + 3'h1;
			end
		end
	end

	// registered pins
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_addr <= 26'h0;
			ext_addr_oe_n <= 1'b0;
			ext_data_out <= 16'h0;
			ext_data_lo_oe_n <= 1'b1;
			ext_data_hi_oe_n <= 1'b1;
			block0_select_n <= 1'b1;
			block3_select_n <= 1'b1;
			block4_select_n <= 1'b1;
			block5_select_n <= 1'b1;
			low_byte_write_n <= 1'b1;
			high_byte_write_n <= 1'b1;
			io_read_n <= 1'b1;
			low_col_strobe_n <= 1'b1;
			high_col_strobe_n <= 1'b1;
			cycle_begin_n <= 1'b1;
			sys_clock_out <= 1'b0;
			dram_access_kind <= 2'h0;
		end else if (clk_en) begin
			ext_addr <= a_addr + {24'h0, pos};
			ext_addr_oe_n <= ~bus_on;
			ext_data_out <= wide_beat ? wsh[15:0] : {wsh[7:0], wsh[7:0]};
			ext_data_lo_oe_n <= ~(run_ext & a_write & use_lo & bus_on);
			// RULE20: upper lane only in boot mode 0
			ext_data_hi_oe_n <= ~(run_ext & a_write & use_hi & bus_on & ~boot_mode1);
			block0_select_n <= ~sel_vec[0];
			block3_select_n <= ~sel_vec[1];
			block4_select_n <= ~sel_vec[2];
			block5_select_n <= ~sel_vec[3];
			low_byte_write_n <= ~(run_ext & a_write & use_lo & ~is_dram & strobe_on);
			// RULE16: no high strobe on 8-bit
			high_byte_write_n <= ~(run_ext & a_write & use_hi & a_w16 & ~is_dram & strobe_on);
			io_read_n <= ~(run_ext & ~a_write & ~is_dram & strobe_on);
			low_col_strobe_n <= ~(run_ext & is_dram & (cnt != 4'h0) & use_lo & strobe_on);
			high_col_strobe_n <= ~(run_ext & is_dram & (cnt != 4'h0) & use_hi & strobe_on);
			cycle_begin_n <= ~(run_ext & (cnt == 4'h0) & strobe_on);
			sys_clock_out <= pin_func[`EBC_PIN_CLK] & ~sys_clock_out;
			dram_access_kind <= dram_kind_select[{a_blk, 1'b0} +: 2];
		end
	end
endmodule // ebc_top

/* verification/ebc_chk.sv */
// port assertions for the external bus block control
`timescale 1ns/1ps
module ebc_chk (
	input wire core_clk, // clock
	input wire sys_rst, // reset
	input wire clk_en, // run enable
	input wire s_axi_arvalid, // read address valid
	input wire s_axi_arready, // read address ready
	input wire [31:0] s_axi_rdata, // read data
	input wire s_axi_rvalid, // read valid
	input wire s_axi_rready, // read ready
	input wire [1:0] s_axi_bresp, // write response
	input wire s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire mem_req, // memory request
	input wire mem_internal, // internal target
	input wire mem_busy, // memory busy
	input wire per_req, // peripheral request
	input wire per_write, // peripheral write
	input wire [1:0] per_class, // register class
	input wire per_ack, // peripheral done
	input wire per_busy, // peripheral busy
	input wire high_byte_write_n, // high write strobe
	input wire ext_data_hi_oe_n, // high lane drive
	input wire sys_clock_out // clock out
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst || !clk_en);
	sequence per_done3;
		!per_ack [*3] ##1 per_ack;
	endsequence
	sequence per_done4;
		!per_ack [*4] ##1 per_ack;
	endsequence
	per_plain_time_a: assert property (per_req && !per_busy && per_class == 2'h0 |-> ##1 per_done3)
		else $error("plain peripheral access not three clocks");
	per_capture_time_a: assert property (per_req && !per_busy && per_class == 2'h1 && !per_write |-> ##1 per_done4)
		else $error("capture read not four clocks");
	per_ack_pulse_a: assert property (per_ack |=> !per_ack)
		else $error("peripheral done longer than one cycle");
	per_busy_set_a: assert property (per_req && !per_busy |=> per_busy)
		else $error("peripheral busy not raised on accept");
	mem_busy_set_a: assert property (mem_req && !mem_busy && !mem_internal |=> mem_busy)
		else $error("memory busy not raised on accept");
	high_lane_drive_a: assert property (!high_byte_write_n |-> !ext_data_hi_oe_n)
		else $error("high strobe without high lane driven");
	clock_out_toggle_a: assert property (1'b1 |=> sys_clock_out != $past(sys_clock_out))
		else $error("clock out did not toggle");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before ready");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before ready");
endmodule // ebc_chk
bind ebc_top ebc_chk u_chk (.*);

/* verification/ebc_mem_model.sv */
// external memory model: answers reads, logs written lanes
`timescale 1ns/1ps
module ebc_mem_model (
	input wire core_clk, // clock
	input wire [25:0] ext_addr, // address bus
	input wire [15:0] ext_data_out, // data from block
	input wire io_read_n, // read strobe
	input wire cycle_begin_n, // cycle start
	input wire low_byte_write_n, // low write strobe
	input wire high_byte_write_n, // high write strobe
	output wire [15:0] ext_data_in // data to block
);
	reg [8:0] log [0:63];
	integer nlog = 0;
	reg junk = 1'b0;
	// released bus shows a changing pattern
	assign ext_data_in = io_read_n ? {16{junk}} : {ext_addr[7:0] ^ 8'h5a, ext_addr[7:0]};
	always @(posedge core_clk) begin
		junk <= ~junk;
		if (!cycle_begin_n && !low_byte_write_n) begin
			log[nlog] = {1'b0, ext_data_out[7:0]};
			nlog = nlog + 1;
		end
		if (!cycle_begin_n && !high_byte_write_n) begin
			log[nlog] = {1'b1, ext_data_out[15:8]};
			nlog = nlog + 1;
		end
	end
endmodule // ebc_mem_model

/* verification/external_bus_block_control_tb_top.sv */
// testbench for the external bus block control
`timescale 1ns/1ps
`include "ebc_defines.vh"
module external_bus_block_control_tb_top;
	reg core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, boot_romless1 = 1'b0, ext_wait_n = 1'b1;
	reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg [31:0] s_axi_wdata = 32'h0, mem_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	reg mem_req = 1'b0, mem_write = 1'b0, mem_fetch = 1'b0, mem_burst = 1'b0, mem_flyby = 1'b0, mem_internal = 1'b0;
	reg [1:0] mem_size = 2'h0, per_class = 2'h0;
	reg [25:0] mem_addr = 26'h0;
	reg per_req = 1'b0, per_write = 1'b0, per_extra_wait = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_ack, mem_busy, per_ack, per_busy;
	wire [1:0] s_axi_bresp, s_axi_rresp, dram_access_kind;
	wire [31:0] s_axi_rdata, mem_rdata;
	wire [25:0] ext_addr;
	wire [15:0] ext_data_out, ext_data_in;
	wire ext_addr_oe_n, ext_data_lo_oe_n, ext_data_hi_oe_n, block0_select_n, block3_select_n, block4_select_n;
	wire block5_select_n, low_byte_write_n, high_byte_write_n, io_read_n, low_col_strobe_n, high_col_strobe_n;
	wire cycle_begin_n, sys_clock_out;
	integer err_count = 0;
	integer checks = 0;
	integer base = 0;
	reg [3:0] sel_seen;
	reg [1:0] cas_seen;
	ebc_top u_dut (.*);
	ebc_mem_model u_mem (.*);
	always #12.5 core_clk = ~core_clk;
	task check(input [63:0] seen, input [63:0] exp, input [8*10-1:0] what);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("MISMATCH %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d err_count %0d", checks, err_count);
			if (err_count == 0 && checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task axi_wr(input [7:0] a, input [31:0] d);
		reg aw, w, b, ta, tw;
		begin
			@(posedge core_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			aw = 1'b1;
			w = 1'b1;
			b = 1'b0;
			while (!b) begin
				@(negedge core_clk);
				ta = aw & s_axi_awready;
				tw = w & s_axi_wready;
				b = !aw & !w & s_axi_bvalid;
				if (b) check(s_axi_bresp, 2'h0, "bresp");
				@(posedge core_clk);
				if (ta) s_axi_awvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
				aw = aw & !ta;
				w = w & !tw;
			end
			s_axi_bready <= 1'b0;
		end
	endtask
	task reg_chk(input [7:0] a, input [31:0] e, input [1:0] er);
		reg ar, got;
		begin
			@(posedge core_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			ar = 1'b1;
			got = 1'b0;
			while (!got) begin
				@(negedge core_clk);
				got = !ar & s_axi_rvalid;
				if (got) check(s_axi_rresp, er, "resp");
				if (got && er == 2'h0) check(s_axi_rdata, e, "reg");
				@(posedge core_clk);
				if (ar & s_axi_arready) s_axi_arvalid <= 1'b0;
				ar = ar & !s_axi_arready;
			end
			s_axi_rready <= 1'b0;
		end
	endtask
	// flags: internal, fetch, burst, flyby
	task mem_op(input [3:0] f, input w, input [1:0] sz, input [25:0] a, input [31:0] d, input integer t);
		integer n;
		begin
			sel_seen = 4'hf;
			cas_seen = 2'h3;
			base = u_mem.nlog;
			@(negedge core_clk);
			while (mem_busy !== 1'b0) @(negedge core_clk);
			@(posedge core_clk);
			{mem_internal, mem_fetch, mem_burst, mem_flyby} <= f;
			mem_write <= w;
			mem_size <= sz;
			mem_addr <= a;
			mem_wdata <= d;
			mem_req <= 1'b1;
			@(posedge core_clk);
			mem_req <= 1'b0;
			n = 0;
			while (mem_ack !== 1'b1) begin
				@(negedge core_clk);
				n = n + 1;
				sel_seen = sel_seen & {block0_select_n, block3_select_n, block4_select_n, block5_select_n};
				cas_seen = cas_seen & {low_col_strobe_n, high_col_strobe_n};
			end
			check(n - 1, t, "mem_clocks");
		end
	endtask
	task per_op(input w, input [1:0] c, input x, input integer t);
		integer n;
		begin
			@(negedge core_clk);
			while (per_busy !== 1'b0) @(negedge core_clk);
			@(posedge core_clk);
			per_write <= w;
			per_class <= c;
			per_extra_wait <= x;
			per_req <= 1'b1;
			@(posedge core_clk);
			per_req <= 1'b0;
			n = 0;
			while (per_ack !== 1'b1) begin
				@(negedge core_clk);
				n = n + 1;
			end
			check(n - 1, t, "per_clocks");
		end
	endtask
	task logs(input integer k, input [35:0] e);
		integer i;
		for (i = 0; i < k; i = i + 1) check(u_mem.log[base + i], e[9*i +: 9], "lane_byte");
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		reg_chk(8'h00, 32'h0, 2'h0);
		reg_chk(8'h04, 32'h5555, 2'h0);
		reg_chk(8'h08, 32'hffffff, 2'h0);
		reg_chk(8'h0c, 32'h0, 2'h0);
		reg_chk(8'h10, 32'hffffffff, 2'h0);
		reg_chk(8'h40, 32'h0, 2'h2);
		check(ext_addr_oe_n, 1'b0, "addr_oe");
		// one setup pass, block 0 off dram, block 0 narrow
		axi_wr(8'h00, 32'h0090);
		axi_wr(8'h04, 32'h5554);
		axi_wr(8'h08, 32'h18);
		axi_wr(8'h0c, 32'h80);
		reg_chk(8'h04, 32'h5554, 2'h0);
		reg_chk(8'h08, 32'h18, 2'h0);
		mem_op(4'h0, 1'b1, `EBC_SZ_HALF, 26'h40, 32'hb2a1, 4);
		logs(2, {18'h0, 9'h0b2, 9'h0a1});
		check(sel_seen, 4'h7, "select");
		mem_op(4'h0, 1'b1, `EBC_SZ_WORD, 26'h44, 32'h44332211, 8);
		logs(4, {9'h044, 9'h033, 9'h022, 9'h011});
		mem_op(4'h0, 1'b0, `EBC_SZ_HALF, 26'h30, 32'h0, 6);
		check(mem_rdata[15:0], 16'h3130, "rdata");
		mem_op(4'h0, 1'b1, `EBC_SZ_WORD, 26'h200040, 32'hd4c3b2a1, 10);
		logs(4, {9'h1d4, 9'h0c3, 9'h1b2, 9'h0a1});
		check(sel_seen, 4'hf, "select");
		mem_op(4'h0, 1'b1, `EBC_SZ_BYTE, 26'h200041, 32'h5e5e5e5e, 5);
		logs(1, {27'h0, 9'h15e});
		mem_op(4'h0, 1'b1, `EBC_SZ_BYTE, 26'h200042, 32'h6f6f6f6f, 5);
		logs(1, {27'h0, 9'h06f});
		// wait pin held low past the programmed waits
		fork
			mem_op(4'h0, 1'b1, `EBC_SZ_BYTE, 26'h51, 32'h77, 4);
			begin
				ext_wait_n <= 1'b0;
				repeat (6) @(posedge core_clk);
				ext_wait_n <= 1'b1;
			end
		join
		mem_op(4'h0, 1'b0, `EBC_SZ_WORD, 26'h400020, 32'h0, 6);
		check(mem_rdata, 32'h78227a20, "rdata");
		mem_op(4'h0, 1'b1, `EBC_SZ_HALF, 26'h800000, 32'h1234, 3);
		check(sel_seen, 4'hb, "select");
		check(dram_access_kind, 2'h2, "dram_kind");
		check(cas_seen, 2'h0, "col_strobe");
		mem_op(4'h2, 1'b1, `EBC_SZ_HALF, 26'h800002, 32'h5678, 1);
		mem_op(4'h1, 1'b1, `EBC_SZ_HALF, 26'h800004, 32'h9abc, 3);
		mem_op(4'h8, 1'b1, `EBC_SZ_WORD, 26'h0, 32'h1, 1);
		mem_op(4'hc, 1'b0, `EBC_SZ_WORD, 26'h2, 32'h0, 2);
		check(sel_seen, 4'hf, "select");
		per_op(1'b1, 2'h0, 1'b0, 3);
		per_op(1'b0, 2'h1, 1'b0, 4);
		per_op(1'b1, 2'h1, 1'b1, 4);
		per_op(1'b1, 2'h2, 1'b0, 3);
		per_op(1'b0, 2'h3, 1'b1, 4);
		fork
			mem_op(4'h0, 1'b1, `EBC_SZ_HALF, 26'h200050, 32'h4321, 5);
			per_op(1'b0, 2'h0, 1'b0, 3);
		join
		// second reset in the other boot mode
		@(posedge core_clk);
		sys_rst <= 1'b1;
		boot_romless1 <= 1'b1;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		reg_chk(8'h04, 32'h0, 2'h0);
		reg_chk(8'h14, 32'h18, 2'h0);
		stop_test;
	end
	initial begin
		#2000000;
		err_count = err_count + 1;
		stop_test;
	end
endmodule // external_bus_block_control_tb_top
